// ==== shared/dsr_pkg.sv ====
// shared constants and types for the dual converter serial readout
package dsr_pkg;
	// ------------------------------------------------------------
	// widths and timing
	// ------------------------------------------------------------
	localparam int RES_W     = 15;     // result word width
	localparam int IDX_W     = 4;      // bit index width
	localparam int CNT_W     = 6;      // conversion counter width
	localparam int CLK_PS    = 5000;   // 200 MHz clock period
	localparam int T_CONV_PS = 171500; // least conversion time
	// least time rounds up to whole cycles
	localparam int CONV_CYC  = (T_CONV_PS + CLK_PS - 1) / CLK_PS;
	localparam int STEP_CYC  = 2;      // cycles per trial bit
	localparam logic [IDX_W-1:0] MSB_IDX = 4'hE;
	localparam logic [RES_W-1:0] TRIAL_MID = 15'h4000;
	// ------------------------------------------------------------
	// code windows of the three drive styles
	// ------------------------------------------------------------
	localparam logic [RES_W-1:0] CODE_FD_MIN  = 15'h4000;
	localparam logic [RES_W-1:0] CODE_FD_MAX  = 15'h3FFF;
	localparam logic [RES_W-1:0] CODE_PDB_MIN = 15'h6000;
	localparam logic [RES_W-1:0] CODE_PDB_MAX = 15'h1FFF;
	localparam logic [RES_W-1:0] CODE_PDU_MIN = 15'h0000;
	localparam logic [RES_W-1:0] CODE_PDU_MAX = 15'h3FFF;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	// three-level mode pin: ground, io supply, floating
	typedef enum logic [1:0] {
		IO_CMOS,
		IO_LVDS,
		IO_LVDS_LP
	} dsr_io_mode_e;
	// conversion sequencer states
	typedef enum logic {
		ST_ACQ,
		ST_CONV
	} dsr_state_e;
	// one pin pair with its drive enables
	typedef struct packed {
		logic p;
		logic n;
		logic p_oe;
		logic n_oe;
	} dsr_pair_s;
	// true for both differential signalling modes
	function automatic logic is_lvds(input dsr_io_mode_e mode);
		return mode != IO_CMOS;
	endfunction : is_lvds
endpackage : dsr_pkg

// ==== src/dsr_sar.sv ====
// successive-approximation search for one channel
`timescale 1ns/100ps
`default_nettype none
module dsr_sar (
	input  wire logic                      sys_clk_in,
	input  wire logic                      rst_n_in,
	input  wire logic                      start_in,
	input  wire logic                      step_in,
	input  wire logic                      comp_in,
	output logic [dsr_pkg::RES_W-1:0]      dac_code_out,
	output logic [dsr_pkg::RES_W-1:0]      result_out,
	output logic                           done_out
);
	// ------------------------------------------------------------
	// search state
	// ------------------------------------------------------------
	logic [dsr_pkg::RES_W-1:0] trial_ff;   // offset-binary trial
	logic [dsr_pkg::IDX_W-1:0] idx_ff;     // bit under test
	logic                      busy_ff;    // search running
	logic [dsr_pkg::RES_W-1:0] nxt_trial;  // trial after decision

	// comparator high means the held sample is at or above the trial
	always_comb begin
		nxt_trial = trial_ff;
		if (!comp_in) begin
			nxt_trial[idx_ff] = 1'b0;
		end
		if (idx_ff != '0) begin
			nxt_trial[idx_ff - 4'h1] = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			trial_ff <= dsr_pkg::TRIAL_MID;
			idx_ff   <= dsr_pkg::MSB_IDX;
			busy_ff  <= 1'b0;
		end else if (start_in) begin
			// restart at mid scale, the sign decision
			trial_ff <= dsr_pkg::TRIAL_MID;
			idx_ff   <= dsr_pkg::MSB_IDX;
			busy_ff  <= 1'b1;
		end else if (busy_ff && step_in) begin
			trial_ff <= nxt_trial;
			idx_ff   <= idx_ff - 4'h1;
			busy_ff  <= idx_ff != '0;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			result_out <= '0;
			done_out   <= 1'b0;
		end else begin
			done_out <= busy_ff && step_in && idx_ff == '0 && !start_in;
			if (busy_ff && step_in && idx_ff == '0 && !start_in) begin
				// full differential span reaches every code
				result_out <= {~nxt_trial[dsr_pkg::RES_W-1],
					nxt_trial[dsr_pkg::RES_W-2:0]};
			end
		end
	end

	// trial code drives the capacitive dac switches
	assign dac_code_out = trial_ff;
endmodule : dsr_sar
`default_nettype wire

// ==== src/dsr_ser.sv ====
// msb-first shifter for one channel's result word
`timescale 1ns/100ps
`default_nettype none
module dsr_ser (
	input  wire logic                      sys_clk_in,
	input  wire logic                      rst_n_in,
	input  wire logic                      load_in,
	input  wire logic [dsr_pkg::RES_W-1:0] word_in,
	input  wire logic                      shift_in,
	output logic                           bit_out,
	output logic                           next_bit_out
);
	// ------------------------------------------------------------
	// shift register
	// ------------------------------------------------------------
	logic [dsr_pkg::RES_W-1:0] sh_ff; // remaining bits, msb first

	// load shows msb, each shift the next
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sh_ff   <= '0;
			bit_out <= 1'b0;
		end else if (load_in) begin
			// load wins so a new frame never starts mid-word
			sh_ff   <= word_in;
			bit_out <= word_in[dsr_pkg::RES_W-1];
		end else if (shift_in) begin
			// zeros trail the word when over-clocked
			sh_ff   <= {sh_ff[dsr_pkg::RES_W-2:0], 1'b0};
			bit_out <= sh_ff[dsr_pkg::RES_W-2];
		end
	end

	// bit that the next shift will present
	assign next_bit_out = sh_ff[dsr_pkg::RES_W-2];
endmodule : dsr_ser
`default_nettype wire

// ==== src/dsr_readout.sv ====
// conversion control and serial readout of the dual converter
`timescale 1ns/100ps
`default_nettype none
module dsr_readout (
	input  wire logic                      sys_clk_in,
	input  wire logic                      rst_n_in,
	input  wire logic                      convert_start_n_in,
	input  wire logic                      sck_p_in,
	input  wire logic                      sck_n_in,
	input  wire dsr_pkg::dsr_io_mode_e     io_mode_in,
	input  wire logic                      echo_neg_tied_in,
	input  wire logic                      ref_buffer_enable_in,
	input  wire logic [1:0]                comparator_in,
	output logic [1:0][dsr_pkg::RES_W-1:0] capacitive_dac_out,
	output logic [1:0][dsr_pkg::RES_W-1:0] result_out,
	output logic [1:0]                     bip_window_out,
	output logic [1:0]                     uni_window_out,
	output logic                           hold_sample_out,
	output logic                           acquire_out,
	output logic                           lvds_low_power_out,
	output logic [1:0]                     ref_buf_on_out,
	output dsr_pkg::dsr_pair_s             chan1_serial_out,
	output dsr_pkg::dsr_pair_s             chan2_serial_out,
	output dsr_pkg::dsr_pair_s             echo_clock_out
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic                      strt_ff;     // start level last cycle
	logic                      sck_ff;      // shift clock last cycle
	logic                      sck_lvl;     // received shift clock
	logic                      strt_fall;   // start falling edge
	logic                      sck_fall;    // shift falling edge
	logic                      step_en;     // one trial per pulse
	logic                      lvds;        // differential mode
	dsr_pkg::dsr_state_e       state_ff;    // sequencer state
	dsr_pkg::dsr_state_e       nxt_state;   // next sequencer state
	logic [dsr_pkg::CNT_W-1:0] conv_cnt_ff; // cycles into conversion
	logic [dsr_pkg::CNT_W-1:0] step_cnt_ff; // step divider
	logic                      oe_ff;       // data pins driven
	logic                      echo_ff;     // echo clock level
	logic [1:0]                bit_w;       // serial bits
	logic [1:0]                next_w;      // bits after next shift
	logic [1:0]                done_w;      // conversion finished
	dsr_pkg::dsr_pair_s [1:0]  pair_w;      // serial pin pairs

	// ------------------------------------------------------------
	// pin receivers
	// ------------------------------------------------------------

	// mode pin selects the receiver and drivers
	assign lvds = dsr_pkg::is_lvds(io_mode_in);

	// low-power variant differs only in driver current
	assign lvds_low_power_out = io_mode_in == dsr_pkg::IO_LVDS_LP;

	// negative shift pin is unconnected in cmos, so ignore it
	assign sck_lvl = lvds ? (sck_p_in && !sck_n_in) : sck_p_in;

	// edge detection on the sampled pin levels
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			strt_ff <= 1'b1;
			sck_ff  <= 1'b0;
		end else begin
			strt_ff <= convert_start_n_in;
			sck_ff  <= sck_lvl;
		end
	end

	// start stays single-ended in every mode
	assign strt_fall = strt_ff && !convert_start_n_in;
	assign sck_fall  = sck_ff && !sck_lvl;

	// ------------------------------------------------------------
	// conversion sequencer
	// ------------------------------------------------------------

	// next state: any start edge opens a fresh conversion
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			dsr_pkg::ST_ACQ: begin
				if (strt_fall) begin
					nxt_state = dsr_pkg::ST_CONV;
				end
			end
			dsr_pkg::ST_CONV: begin
				if (!strt_fall &&
					conv_cnt_ff == dsr_pkg::CNT_W'(dsr_pkg::CONV_CYC - 1)) begin
					nxt_state = dsr_pkg::ST_ACQ;
				end
			end
			default: begin
				nxt_state = dsr_pkg::ST_ACQ;
			end
		endcase
	end

	// falling edge enters hold at once
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_ff <= dsr_pkg::ST_ACQ;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// conversion length counter, restarted by every start edge
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			conv_cnt_ff <= '0;
		end else if (strt_fall || state_ff != dsr_pkg::ST_CONV) begin
			conv_cnt_ff <= '0;
		end else begin
			conv_cnt_ff <= conv_cnt_ff + 6'h01;
		end
	end

	// step divider; trading speed for settling, two cycles a bit
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			step_cnt_ff <= '0;
		end else if (strt_fall || step_en) begin
			step_cnt_ff <= '0;
		end else if (state_ff == dsr_pkg::ST_CONV) begin
			step_cnt_ff <= step_cnt_ff + 6'h01;
		end
	end

	// one-cycle trial pulse
	assign step_en = state_ff == dsr_pkg::ST_CONV &&
		step_cnt_ff == dsr_pkg::CNT_W'(dsr_pkg::STEP_CYC - 1);

	assign hold_sample_out = state_ff == dsr_pkg::ST_CONV;
	assign acquire_out     = state_ff == dsr_pkg::ST_ACQ;

	// enable pin gates both reference buffers
	assign ref_buf_on_out = {2{ref_buffer_enable_in}};

	// ------------------------------------------------------------
	// per-channel converter and shifter
	// ------------------------------------------------------------
	for (genvar g = 0; g < 2; g++) begin : g_chan
		logic bip_ff; // result inside bipolar window
		logic uni_ff; // result inside unipolar window

		// search runs on its own comparator
		dsr_sar u_sar (
			.sys_clk_in   (sys_clk_in),
			.rst_n_in     (rst_n_in),
			.start_in     (strt_fall),
			.step_in      (step_en),
			.comp_in      (comparator_in[g]),
			.dac_code_out (capacitive_dac_out[g]),
			.result_out   (result_out[g]),
			.done_out     (done_w[g])
		);

		// start edge loads the previous result
		dsr_ser u_ser (
			.sys_clk_in   (sys_clk_in),
			.rst_n_in     (rst_n_in),
			.load_in      (strt_fall),
			.word_in      (result_out[g]),
			.shift_in     (sck_fall && oe_ff),
			.bit_out      (bit_w[g]),
			.next_bit_out (next_w[g])
		);

		always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				bip_ff <= 1'b0;
				uni_ff <= 1'b0;
			end else if (done_w[g]) begin
				bip_ff <= $signed(result_out[g]) >=
					$signed(dsr_pkg::CODE_PDB_MIN) &&
					$signed(result_out[g]) <=
					$signed(dsr_pkg::CODE_PDB_MAX);
				uni_ff <= $signed(result_out[g]) >=
					$signed(dsr_pkg::CODE_PDU_MIN) &&
					$signed(result_out[g]) <=
					$signed(dsr_pkg::CODE_PDU_MAX);
			end
		end
		assign bip_window_out[g] = bip_ff;
		assign uni_window_out[g] = uni_ff;

		assign pair_w[g].p    = bit_w[g];
		assign pair_w[g].n    = !bit_w[g];
		assign pair_w[g].p_oe = oe_ff;
		assign pair_w[g].n_oe = oe_ff && lvds;
	end

	assign chan1_serial_out = pair_w[0];
	assign chan2_serial_out = pair_w[1];

	// ------------------------------------------------------------
	// output enable and echo clock
	// ------------------------------------------------------------

	// start high releases the data pins
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			oe_ff <= 1'b0;
		end else begin
			oe_ff <= !convert_start_n_in;
		end
	end

	// echo shares the data's one-cycle delay
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			echo_ff <= 1'b0;
		end else begin
			echo_ff <= sck_lvl;
		end
	end

	// tied negative pin turns cmos echo off
	assign echo_clock_out.p    = echo_ff;
	assign echo_clock_out.n    = !echo_ff;
	assign echo_clock_out.p_oe = lvds || !echo_neg_tied_in;
	assign echo_clock_out.n_oe = lvds;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	AST_HOLD_ON_START: assert property (
		strt_fall |=> hold_sample_out && conv_cnt_ff == '0)
		else $error("no hold after start edge");

	AST_BACK_TO_ACQ: assert property (
		hold_sample_out && !strt_fall &&
		conv_cnt_ff == dsr_pkg::CNT_W'(dsr_pkg::CONV_CYC - 1)
		|=> acquire_out)
		else $error("conversion did not end");

	// search finishes inside the conversion time
	AST_DONE_IN_TIME: assert property (
		$rose(hold_sample_out) ##1 !strt_fall [*8]
		|-> ##[20:25] done_w[0])
		else $error("result not ready in time");

	AST_MSB_FIRST: assert property (
		strt_fall |=> chan1_serial_out.p ==
		$past(result_out[0][dsr_pkg::RES_W-1]))
		else $error("first bit is not the msb");

	// each falling edge while the data pins are driven, with no start edge, presents the next bit
	AST_SHIFT_NEXT: assert property (
		sck_fall && oe_ff && !strt_fall
		|=> chan2_serial_out.p == $past(next_w[1]))
		else $error("shift did not advance one bit");

	// released one cycle after start high
	AST_RELEASE: assert property (
		convert_start_n_in |=> !chan1_serial_out.p_oe &&
		!chan2_serial_out.p_oe)
		else $error("data pins still driven");

	// negative pins stay undriven in cmos
	AST_CMOS_NEG: assert property (
		!lvds |-> !chan1_serial_out.n_oe && !chan2_serial_out.n_oe)
		else $error("negative pin driven in cmos");

	AST_LVDS_PAIR: assert property (
		lvds && chan1_serial_out.p_oe |-> chan1_serial_out.n_oe &&
		chan1_serial_out.n != chan1_serial_out.p)
		else $error("lvds pair not complementary");

	// echo falls with the data change
	AST_ECHO_EDGE: assert property (
		sck_fall |=> !echo_clock_out.p)
		else $error("echo did not follow shift clock");

	// tied negative pin silences the cmos echo
	AST_ECHO_OFF: assert property (
		!lvds && echo_neg_tied_in |-> !echo_clock_out.p_oe)
		else $error("echo driven while disabled");

	// grounded enable turns both buffers off
	AST_REF_OFF: assert property (
		!ref_buffer_enable_in |-> ref_buf_on_out == 2'h0)
		else $error("reference buffer left on");

	// main scenarios
	COV_LVDS_FRAME: cover property (lvds ##0 strt_fall ##[1:40] sck_fall);
	COV_CONV_DONE: cover property (done_w[0] && done_w[1]);
	COV_ECHO_OFF: cover property (!lvds && echo_neg_tied_in && strt_fall);
endmodule : dsr_readout
`default_nettype wire

// ==== verif/dsr_host_model.sv ====
// host model: drives start and shift clock, captures both serial words
`timescale 1ns/100ps
`default_nettype none
module dsr_host_model (
	input  wire logic                 clk_in,
	input  wire logic                 lvds_in,
	input  wire dsr_pkg::dsr_pair_s   ch1_in,
	input  wire dsr_pkg::dsr_pair_s   ch2_in,
	output logic                      start_n_out,
	output logic                      sck_p_out,
	output logic                      sck_n_out,
	output logic [dsr_pkg::RES_W-1:0] word1_out,
	output logic [dsr_pkg::RES_W-1:0] word2_out
);
	logic lvl_ff; // wanted shift clock level, low between frames
	initial begin
		start_n_out = 1'b1;
		sck_p_out = 1'b0;
		sck_n_out = 1'b1;
		lvl_ff = 1'b0;
		word1_out = 15'h0000;
		word2_out = 15'h0000;
	end
	// pins per mode
	// the unused negative pin toggles so a design reading it is caught
	always @(posedge clk_in) begin
		sck_p_out <= lvl_ff;
		sck_n_out <= lvds_in ? ~lvl_ff : ~sck_n_out;
	end
	// start edge, fifteen bits
	// h+1 cycles high and h cycles low per bit keep the shift clock well under its limit
	task automatic frame(input int h);
		int i;
		start_n_out <= 1'b0;
		repeat (3) @(posedge clk_in);
		for (i = 14; i >= 0; i--) begin
			lvl_ff <= 1'b1;
			repeat (h) @(posedge clk_in);
			@(negedge clk_in);
			// an undriven pin reads back inverted, so a late capture shows
			word1_out[i] = ch1_in.p_oe ? ch1_in.p : !ch1_in.p;
			word2_out[i] = ch2_in.p_oe ? ch2_in.p : !ch2_in.p;
			@(posedge clk_in);
			lvl_ff <= 1'b0;
			repeat (h) @(posedge clk_in);
		end
	endtask : frame
	task automatic pulse(input int n);
		start_n_out <= 1'b0;
		repeat (n) @(posedge clk_in);
		start_n_out <= 1'b1;
		repeat (2) @(posedge clk_in);
	endtask : pulse
	// end of frame: start back high
	task automatic release_start;
		start_n_out <= 1'b1;
		repeat (2) @(posedge clk_in);
	endtask : release_start
endmodule : dsr_host_model
`default_nettype wire

// ==== verif/tb_top.sv ====
// self-checking bench of the dual converter readout
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	localparam int W = dsr_pkg::RES_W;
	logic                  sys_clk_in = 1'b0;
	logic                  rst_n_in   = 1'b0;
	dsr_pkg::dsr_io_mode_e io_mode    = dsr_pkg::IO_CMOS;
	logic                  echo_tied  = 1'b0;
	logic                  ref_en     = 1'b1;
	logic [W-1:0]          v1 = 15'h0000; // held samples, offset binary
	logic [W-1:0]          v2 = 15'h0000;
	logic [W-1:0]          exp1 = 15'h0000; // model: last results
	logic [W-1:0]          exp2 = 15'h0000;
	logic [W-1:0]          q1 [$]; // model: words awaiting readout
	logic [W-1:0]          q2 [$];
	logic [1:0]            cmp;
	logic                  lvds;
	logic                  start_n, sck_p, sck_n, hold, acq, lowp;
	logic [1:0][W-1:0]     dac, res;
	logic [1:0]            bipw, uniw, refon;
	dsr_pkg::dsr_pair_s    ch1, ch2, echo;
	logic [W-1:0]          w1, w2;
	logic [15:0]           rnd = 16'h1D19;
	logic                  sck_d = 1'b0;
	int mismatches = 0, samples_checked = 0, cycles = 0;
	int sck_st = 0, hold_len = 0, hold_done = 0;
	logic [W-1:0] tbl [8] = '{15'h0000, 15'h7FFF, 15'h4000, 15'h3FFF,
		15'h2000, 15'h5FFF, 15'h1FFF, 15'h6000};
	// ------------------------------------------------------------
	// design, host and comparator models
	// ------------------------------------------------------------
	assign lvds = io_mode != dsr_pkg::IO_CMOS;
	// ideal comparator: sample at or above the trial code
	assign cmp = {v2 >= dac[1], v1 >= dac[0]};
	always #2.5 sys_clk_in = ~sys_clk_in;
	dsr_readout dsr_readout_i (.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in), .convert_start_n_in(start_n),
		.sck_p_in(sck_p), .sck_n_in(sck_n), .io_mode_in(io_mode),
		.echo_neg_tied_in(echo_tied), .ref_buffer_enable_in(ref_en),
		.comparator_in(cmp), .capacitive_dac_out(dac),
		.result_out(res), .bip_window_out(bipw), .uni_window_out(uniw),
		.hold_sample_out(hold), .acquire_out(acq),
		.lvds_low_power_out(lowp), .ref_buf_on_out(refon),
		.chan1_serial_out(ch1), .chan2_serial_out(ch2),
		.echo_clock_out(echo));
	dsr_host_model dsr_host_model_i (.clk_in(sys_clk_in),
		.lvds_in(lvds), .ch1_in(ch1), .ch2_in(ch2),
		.start_n_out(start_n), .sck_p_out(sck_p), .sck_n_out(sck_n),
		.word1_out(w1), .word2_out(w2));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	function automatic logic in_bip(input logic [W-1:0] r);
		return r[W-1] ? (r >= 15'h6000) : (r <= 15'h1FFF);
	endfunction : in_bip
	task automatic check_val(input string what, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s exp %h got %h", what, e, g);
		end
	endtask : check_val
	task automatic check_bit(input string what, input logic e, g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s exp %b got %b", what, e, g);
		end
	endtask : check_bit
	task automatic finish_test;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test
	// one conversion with readout of the previous result
	task automatic conv(input logic [W-1:0] a, b, input int h, len);
		int k;
		v1 <= a;
		v2 <= b;
		dsr_host_model_i.frame(h);
		for (k = 0; k < 100 && hold === 1'b1; k++)
			@(posedge sys_clk_in);
		dsr_host_model_i.release_start();
		@(negedge sys_clk_in);
		check_bit("data oe", 1'b0, ch1.p_oe);
		check_val("hold len", len, hold_done);
		check_val("word1", q1.pop_front(), w1);
		check_val("word2", q2.pop_front(), w2);
		exp1 = a ^ 15'h4000;
		exp2 = b ^ 15'h4000;
		q1.push_back(exp1);
		q2.push_back(exp2);
		check_val("res1", exp1, res[0]);
		check_val("res2", exp2, res[1]);
		check_bit("bip1", in_bip(exp1), bipw[0]);
		check_bit("bip2", in_bip(exp2), bipw[1]);
		check_bit("uni1", ~exp1[W-1], uniw[0]);
		check_bit("uni2", ~exp2[W-1], uniw[1]);
		@(posedge sys_clk_in);
	endtask : conv
	// cycle count, shift clock stability and hold length
	always @(posedge sys_clk_in) begin
		cycles <= cycles + 1;
		sck_d <= sck_p;
		sck_st <= (sck_p === sck_d) ? sck_st + 1 : 0;
		hold_len <= (hold === 1'b1) ? hold_len + 1 : 0;
		if (hold === 1'b0 && hold_len != 0)
			hold_done <= hold_len;
		if (cycles == 5000) begin
			mismatches++;
			finish_test();
		end
	end
	// pin level checks on every cycle out of reset, away from the active edge
	always @(negedge sys_clk_in) begin
		if (rst_n_in) begin
			check_bit("n oe1", ch1.p_oe & lvds, ch1.n_oe);
			check_bit("n oe2", ch2.p_oe & lvds, ch2.n_oe);
			check_bit("oe pair", ch1.p_oe, ch2.p_oe);
			if (ch1.p_oe === 1'b1 && lvds) begin
				check_bit("n1", ~ch1.p, ch1.n);
				check_bit("n2", ~ch2.p, ch2.n);
			end
			check_bit("echo p oe", lvds | ~echo_tied, echo.p_oe);
			check_bit("echo n oe", lvds, echo.n_oe);
			if (sck_st > 0)
				check_bit("echo", sck_d, echo.p);
			check_bit("low pwr", io_mode == dsr_pkg::IO_LVDS_LP, lowp);
			check_bit("ref1", ref_en, refon[0]);
			check_bit("ref2", ref_en, refon[1]);
			check_bit("acquire", ~hold, acq);
		end
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		int i;
		repeat (16) @(posedge sys_clk_in);
		@(negedge sys_clk_in);
		check_bit("acq rst", 1'b1, acq);
		check_val("dac rst", 15'h4000, dac[0]);
		check_val("res rst", 15'h0000, res[0]);
		check_bit("oe rst", 1'b0, ch1.p_oe);
		@(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		repeat (2) @(posedge sys_clk_in);
		$display("test reset done");
		// first frame reads back the cleared result words
		q1.push_back(15'h0000);
		q2.push_back(15'h0000);
		for (i = 0; i < 8; i++) begin
			io_mode <= dsr_pkg::dsr_io_mode_e'(i % 3);
			echo_tied <= i[1];
			rnd = lfsr(rnd);
			@(posedge sys_clk_in);
			conv(tbl[i], rnd[W-1:0], 2 + 2 * (i % 2), 35);
		end
		$display("test boundary codes done");
		rnd = lfsr(rnd);
		v1 <= rnd[W-1:0];
		v2 <= ~rnd[W-1:0];
		dsr_host_model_i.pulse(4);
		check_val("res kept", exp1, res[0]);
		conv(15'h1234, 15'h6ABC, 2, 41);
		$display("test restart done");
		for (i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			io_mode <= dsr_pkg::dsr_io_mode_e'(rnd[1:0] % 2'h3);
			echo_tied <= rnd[2];
			ref_en <= rnd[3];
			@(posedge sys_clk_in);
			rnd = lfsr(rnd);
			conv(rnd[W-1:0], {rnd[7:0], rnd[15:9]}, 2 + 2 * rnd[4], 35);
		end
		$display("test random done");
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
